// ---- hdl/pfl_pkg.sv ----
// constants for the pfd control and lock detect block
package pfl_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] REG_CORE_CTRL_IDX = 8'h01;
    localparam logic [7:0] REG_PFD_CTRL_IDX = 8'h05;
    localparam logic [7:0] REG_LOCK_CFG_IDX = 8'h1a;
    localparam logic [7:0] REG_GPO_CFG_IDX = 8'h1b;
    localparam logic [7:0] REG_LOCK_STAT_IDX = 8'h1f;
    // core_ctrl fields
    localparam int LKD_EN_BIT = 11;
    // pfd_ctrl fields
    localparam int PHASE_INV_BIT = 0;
    localparam int UP_EN_BIT = 1;
    localparam int DN_EN_BIT = 2;
    localparam int PFD_CTRL_W = 3;
    // lock_cfg fields
    localparam int WINCNT_MAX_LSB = 0;
    localparam int WINCNT_W = 10;
    localparam int AUTO_SHARE_BIT = 12;
    localparam int PIN_ALWAYS_BIT = 13;
    localparam int WIN_DIGITAL_BIT = 14;
    localparam int RING_CFG_LSB = 15;
    localparam int RING_DUR_LSB = 17;
    localparam int RING_TEST_BIT = 19;
    localparam int LOCK_CFG_W = 20;
    // gpo_cfg fields
    localparam int GPO_SEL_W = 4;
    localparam logic [3:0] GPO_SEL_AUX_OSC = 4'h7;
    // lock_status fields
    localparam int LOCKED_BIT = 0;
    // reset values
    localparam logic CORE_LKD_EN_RST = 1'b0;
    localparam logic [2:0] PFD_CTRL_RST = 3'h0;
    localparam logic [19:0] LOCK_CFG_RST = 20'h00000;
    localparam logic [3:0] GPO_SEL_RST = 4'h0;
    // timing: analog window rounded up to whole cycles
    localparam int CLK_PERIOD_NS = 8;
    localparam int ANALOG_WIN_NS = 10;
    localparam int ANALOG_WIN_CYC = (ANALOG_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WIN_CNT_W = 6;
    // ahb-lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : pfl_pkg

// ---- hdl/pfl_top.sv ----
// pfd polarity/masking, lock detector and register slave
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
// Function
// - A set polarity bit swaps the up and down pump commands.
// - A cleared up enable masks the up pump command.
// - A cleared down enable masks the down pump command.
// - Both enables cleared puts the pump in high impedance while all else runs.
// - Lock detection runs only while the lock detect enable is set.
// - Window source bit clear gives the fixed short window, set gives the digital window.
// - A two-bit field sets the ring oscillator that times the digital window.
// - A two-bit field sets how many ring periods the digital window lasts.
// - Ring test bit with output select code seven shows the ring on the second output.
// - Lock detection does not run while the ring test mode is on.
// - Consecutive in-window arrivals are counted and lock is declared at the programmed maximum.
// - On lock the flag at bit zero of the lock status register is set.
// - One arrival outside the window clears the flag and restarts the count.
// - The flag is read-only to software and writes leave it alone.
// - The always-show bit drives the flag onto the shared pin continuously.
// - With auto share set and always-show clear the pin shows the flag except during a serial read.
module pfl_top
    import pfl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // detector edges, one-cycle pulses
    input wire logic ref_edge_i,
    input wire logic vco_edge_i,
    // charge pump control
    output logic pump_up_o,
    output logic pump_dn_o,
    output logic pump_hiz_o,
    // serial port readback sharing
    input wire logic serial_read_i,
    input wire logic serial_sdo_i,
    output logic shared_flag_readback_pin_o,
    // status
    output logic general_output_two_o,
    output logic locked_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // register slave

    function automatic logic [8:0] decode(input logic [31:0] addr);
        // bit 8 marks a mapped index
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[31:10] != 22'h0 || addr[1:0] != 2'b00) begin
            decode = 9'h000;
        end else if (idx == REG_CORE_CTRL_IDX || idx == REG_PFD_CTRL_IDX ||
                     idx == REG_LOCK_CFG_IDX || idx == REG_GPO_CFG_IDX ||
                     idx == REG_LOCK_STAT_IDX) begin
            decode = {1'b1, idx};
        end else begin
            decode = 9'h000;
        end
    endfunction : decode

    logic lkd_en, next_lkd_en;
    logic [PFD_CTRL_W-1:0] pfd_ctrl, next_pfd_ctrl;
    logic [LOCK_CFG_W-1:0] lock_cfg, next_lock_cfg;
    logic [GPO_SEL_W-1:0] gpo_sel, next_gpo_sel;
    logic wr_pend, next_wr_pend;
    logic [8:0] wr_idx, next_wr_idx;
    logic [31:0] next_hrdata;
    logic locked;
    logic addr_ok;
    logic [8:0] rd_idx;

    always_comb begin
        addr_ok = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
        rd_idx = decode(haddr_i);
        next_wr_pend = addr_ok && hwrite_i;
        next_wr_idx = rd_idx;
        next_hrdata = hrdata_o;
        if (addr_ok && !hwrite_i) begin
            next_hrdata = 32'h00000000;
            if (rd_idx == {1'b1, REG_CORE_CTRL_IDX}) begin
                next_hrdata[LKD_EN_BIT] = lkd_en;
            end else if (rd_idx == {1'b1, REG_PFD_CTRL_IDX}) begin
                next_hrdata[PFD_CTRL_W-1:0] = pfd_ctrl;
            end else if (rd_idx == {1'b1, REG_LOCK_CFG_IDX}) begin
                next_hrdata[LOCK_CFG_W-1:0] = lock_cfg;
            end else if (rd_idx == {1'b1, REG_GPO_CFG_IDX}) begin
                next_hrdata[GPO_SEL_W-1:0] = gpo_sel;
            end else if (rd_idx == {1'b1, REG_LOCK_STAT_IDX}) begin
                next_hrdata[LOCKED_BIT] = locked;
            end
        end
        next_lkd_en = lkd_en;
        next_pfd_ctrl = pfd_ctrl;
        next_lock_cfg = lock_cfg;
        next_gpo_sel = gpo_sel;
        // lock status index has no write branch, so the flag is untouched
        if (wr_pend) begin
            if (wr_idx == {1'b1, REG_CORE_CTRL_IDX}) begin
                next_lkd_en = hwdata_i[LKD_EN_BIT];
            end else if (wr_idx == {1'b1, REG_PFD_CTRL_IDX}) begin
                next_pfd_ctrl = hwdata_i[PFD_CTRL_W-1:0];
            end else if (wr_idx == {1'b1, REG_LOCK_CFG_IDX}) begin
                next_lock_cfg = hwdata_i[LOCK_CFG_W-1:0];
            end else if (wr_idx == {1'b1, REG_GPO_CFG_IDX}) begin
                next_gpo_sel = hwdata_i[GPO_SEL_W-1:0];
            end
        end
    end

    // zero wait states: read data is prepared during the address phase
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            lkd_en <= CORE_LKD_EN_RST;
            pfd_ctrl <= PFD_CTRL_RST;
            lock_cfg <= LOCK_CFG_RST;
            gpo_sel <= GPO_SEL_RST;
            wr_pend <= 1'b0;
            wr_idx <= 9'h000;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b0;
            hresp_o <= HRESP_OKAY;
        end else begin
            lkd_en <= next_lkd_en;
            pfd_ctrl <= next_pfd_ctrl;
            lock_cfg <= next_lock_cfg;
            gpo_sel <= next_gpo_sel;
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
            hrdata_o <= next_hrdata;
            hreadyout_o <= 1'b1;
            hresp_o <= HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase detector and pump masking

    logic pfd_up, pfd_dn, next_pfd_up, next_pfd_dn;
    logic next_pump_up, next_pump_dn, next_pump_hiz;
    logic cmd_up, cmd_dn;

    always_comb begin
        next_pfd_up = pfd_up | ref_edge_i;
        next_pfd_dn = pfd_dn | vco_edge_i;
        // both latched means both edges seen: detector resets
        if (next_pfd_up && next_pfd_dn) begin
            next_pfd_up = 1'b0;
            next_pfd_dn = 1'b0;
        end
        cmd_up = pfd_ctrl[PHASE_INV_BIT] ? pfd_dn : pfd_up;
        cmd_dn = pfd_ctrl[PHASE_INV_BIT] ? pfd_up : pfd_dn;
        next_pump_up = cmd_up & pfd_ctrl[UP_EN_BIT];
        next_pump_dn = cmd_dn & pfd_ctrl[DN_EN_BIT];
        next_pump_hiz = !pfd_ctrl[UP_EN_BIT] && !pfd_ctrl[DN_EN_BIT];
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pfd_up <= 1'b0;
            pfd_dn <= 1'b0;
            pump_up_o <= 1'b0;
            pump_dn_o <= 1'b0;
            pump_hiz_o <= 1'b1;
        end else begin
            pfd_up <= next_pfd_up;
            pfd_dn <= next_pfd_dn;
            pump_up_o <= next_pump_up;
            pump_dn_o <= next_pump_dn;
            pump_hiz_o <= next_pump_hiz;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ring oscillator and lock window

    logic [1:0] ring_half, next_ring_half;
    logic ring, next_ring;
    logic [WIN_CNT_W-1:0] win_left, next_win_left, win_len;
    logic in_window;
    logic [1:0] ring_cfg, ring_dur;

    always_comb begin
        ring_cfg = lock_cfg[RING_CFG_LSB +: 2];
        ring_dur = lock_cfg[RING_DUR_LSB +: 2];
        // ring half period is cfg+1 cycles; free running model of the oscillator
        next_ring_half = ring_half + 2'd1;
        next_ring = ring;
        if (ring_half >= ring_cfg) begin
            next_ring_half = 2'd0;
            next_ring = !ring;
        end
        // digital window spans dur+1 ring periods
        if (lock_cfg[WIN_DIGITAL_BIT]) begin
            win_len = WIN_CNT_W'((ring_dur + 3'd1) * (ring_cfg + 3'd1) * 2);
        end else begin
            win_len = WIN_CNT_W'(ANALOG_WIN_CYC);
        end
        in_window = ref_edge_i || (win_left != '0);
        if (ref_edge_i) begin
            next_win_left = win_len - WIN_CNT_W'(1);
        end else if (win_left != '0) begin
            next_win_left = win_left - WIN_CNT_W'(1);
        end else begin
            next_win_left = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ring_half <= 2'd0;
            ring <= 1'b0;
            win_left <= '0;
        end else begin
            ring_half <= next_ring_half;
            ring <= next_ring;
            win_left <= next_win_left;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lock counter and flag

    logic [WINCNT_W-1:0] hit_cnt, next_hit_cnt, cnt_max;
    logic next_locked, det_on;

    always_comb begin
        cnt_max = lock_cfg[WINCNT_MAX_LSB +: WINCNT_W];
        det_on = lkd_en && !lock_cfg[RING_TEST_BIT];
        next_hit_cnt = hit_cnt;
        next_locked = locked;
        if (!det_on) begin
            next_hit_cnt = '0;
            next_locked = 1'b0;
        end else if (vco_edge_i && !in_window) begin
            next_hit_cnt = '0;
            next_locked = 1'b0;
        end else if (vco_edge_i) begin
            if (hit_cnt != '1) begin
                next_hit_cnt = hit_cnt + WINCNT_W'(1);
            end
            if (next_hit_cnt >= cnt_max) begin
                next_locked = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            hit_cnt <= '0;
            locked <= 1'b0;
        end else begin
            hit_cnt <= next_hit_cnt;
            locked <= next_locked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared pin and test output

    logic next_pin, next_general_output_two;

    always_comb begin
        if (lock_cfg[PIN_ALWAYS_BIT]) begin
            next_pin = locked;
        end else if (lock_cfg[AUTO_SHARE_BIT]) begin
            next_pin = serial_read_i ? serial_sdo_i : locked;
        end else begin
            next_pin = serial_sdo_i;
        end
        // other output selections are outside this block and read low
        next_general_output_two = lock_cfg[RING_TEST_BIT] && gpo_sel == GPO_SEL_AUX_OSC && ring;
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            shared_flag_readback_pin_o <= 1'b0;
            general_output_two_o <= 1'b0;
            locked_flag_o <= 1'b0;
        end else begin
            shared_flag_readback_pin_o <= next_pin;
            general_output_two_o <= next_general_output_two;
            locked_flag_o <= locked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    a_polarity_swap: assert property (pfd_ctrl == 3'b111 && pfd_dn |=> pump_up_o && !pump_dn_o)
        else $error("inverted polarity did not swap pump commands");
    a_up_mask: assert property (!pfd_ctrl[UP_EN_BIT] |=> !pump_up_o)
        else $error("masked up command reached pump");
    a_dn_mask: assert property (!pfd_ctrl[DN_EN_BIT] |=> !pump_dn_o)
        else $error("masked down command reached pump");
    a_pump_hiz: assert property (!pfd_ctrl[UP_EN_BIT] && !pfd_ctrl[DN_EN_BIT] |=> pump_hiz_o)
        else $error("pump not high impedance with both enables clear");
    a_detect_off: assert property (!lkd_en |=> hit_cnt == '0 && !locked)
        else $error("lock detection ran while disabled");
    a_ring_test: assert property (lock_cfg[RING_TEST_BIT] |=> !locked)
        else $error("lock declared in ring test mode");
    a_lock_reach: assert property (det_on && vco_edge_i && in_window
        && hit_cnt + 11'd1 >= {1'b0, cnt_max} |=> locked ##1 locked_flag_o)
        else $error("lock not declared at programmed count");
    a_miss_clear: assert property (det_on && vco_edge_i && !in_window
        |=> !locked && hit_cnt == '0)
        else $error("out-of-window arrival did not clear lock");
    a_flag_pin: assert property (lock_cfg[PIN_ALWAYS_BIT] |=> shared_flag_readback_pin_o == $past(locked))
        else $error("shared pin does not show lock flag");
    a_auto_share: assert property (!lock_cfg[PIN_ALWAYS_BIT] && lock_cfg[AUTO_SHARE_BIT]
        && serial_read_i |=> shared_flag_readback_pin_o == $past(serial_sdo_i))
        else $error("shared pin did not carry read data");
    a_ring_out: assert property (lock_cfg[RING_TEST_BIT] && gpo_sel == GPO_SEL_AUX_OSC
        |=> general_output_two_o == $past(ring))
        else $error("ring oscillator not on second output");

endmodule : pfl_top

// ---- verification/pfl_host.sv ----
// host model: ahb-lite master and serial read driver
`timescale 1ns/1ns
module pfl_host
    import pfl_pkg::*;
(
    // clock
    input wire logic clk_sys_i,
    // ahb-lite master
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o,
    // serial readback
    output logic serial_read_o,
    output logic serial_sdo_o
);
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
        serial_read_o = 1'b0;
        serial_sdo_o = 1'b1;
    end
    ////////////////////////
    // one word transfer; caller enters right after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel_o <= 1'b1;
        haddr_o <= a;
        htrans_o <= HTRANS_NONSEQ;
        hwrite_o <= w;
        @(posedge clk_sys_i);
        while (hready_i !== 1'b1) @(posedge clk_sys_i);
        hsel_o <= 1'b0;
        htrans_o <= 2'b00;
        hwdata_o <= d;
        @(posedge clk_sys_i);
        while (hready_i !== 1'b1) @(posedge clk_sys_i);
        q = hrdata_i;
    endtask : xfer
    ////////////////////////
    task automatic serial_bit(input logic b);
        @(posedge clk_sys_i);
        serial_read_o <= 1'b1;
        serial_sdo_o <= b;
        @(posedge clk_sys_i);
    endtask : serial_bit
    // released line shows the inverse, so a stale value never passes
    task automatic serial_end();
        @(posedge clk_sys_i);
        serial_read_o <= 1'b0;
        serial_sdo_o <= ~serial_sdo_o;
        @(posedge clk_sys_i);
    endtask : serial_end
endmodule : pfl_host

// ---- verification/pfd_control_lock_detect_test.sv ----
// self-checking bench for the pfd control and lock detect block
`timescale 1ns/1ns
module pfd_control_lock_detect_test
    import pfl_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic ref_edge = 1'b0;
    logic vco_edge = 1'b0;
    logic hsel, hwrite, hready, hresp, pump_up, pump_dn, pump_hiz;
    logic serial_read, serial_sdo, pin, general_output_two, locked;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, v;
    int miscompares = 0;
    int comparisons = 0;
    int mx, wl, d, tg;
    always #4 clk_sys_i = ~clk_sys_i;
    pfl_top u_pfl_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .ref_edge_i(ref_edge), .vco_edge_i(vco_edge),
        .pump_up_o(pump_up), .pump_dn_o(pump_dn), .pump_hiz_o(pump_hiz),
        .serial_read_i(serial_read), .serial_sdo_i(serial_sdo),
        .shared_flag_readback_pin_o(pin), .general_output_two_o(general_output_two),
        .locked_flag_o(locked));
    pfl_host u_pfl_host (.clk_sys_i(clk_sys_i), .hready_i(hready), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata), .serial_read_o(serial_read),
        .serial_sdo_o(serial_sdo));
    ////////////////////////
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc
    task automatic wr(input logic [7:0] idx, input logic [31:0] dat);
        logic [31:0] q;
        @(posedge clk_sys_i);
        u_pfl_host.xfer(1'b1, {22'h0, idx, 2'b00}, dat, q);
    endtask : wr
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        @(posedge clk_sys_i);
        u_pfl_host.xfer(1'b0, {22'h0, idx, 2'b00}, 32'h0, q);
        check(q, exp);
    endtask : rd_chk
    // reference pulse, then divided vco pulse off cycles later
    task automatic pulse(input int off);
        @(posedge clk_sys_i);
        for (int i = 0; i <= off; i++) begin
            ref_edge <= (i == 0);
            vco_edge <= (i == off);
            @(posedge clk_sys_i);
        end
        ref_edge <= 1'b0;
        vco_edge <= 1'b0;
        cyc(4);
        #1;
    endtask : pulse
    task automatic one(input logic r, input logic f);
        @(posedge clk_sys_i);
        ref_edge <= r;
        vco_edge <= f;
        @(posedge clk_sys_i);
        ref_edge <= 1'b0;
        vco_edge <= 1'b0;
        cyc(3);
        #1;
    endtask : one
    task automatic toggles(output int n);
        logic last;
        n = 0;
        // sample after the edge settles, never in its own time step
        #1;
        last = general_output_two;
        repeat (16) begin
            @(posedge clk_sys_i);
            #1;
            if (general_output_two !== last) n++;
            last = general_output_two;
        end
    endtask : toggles
    // {up, dn, hiz} after a lone edge
    function automatic logic [2:0] pump_exp(input logic [2:0] c, input logic ref_first);
        logic up;
        up = ref_first ^ c[PHASE_INV_BIT];
        return {up & c[UP_EN_BIT], ~up & c[DN_EN_BIT], ~c[UP_EN_BIT] & ~c[DN_EN_BIT]};
    endfunction : pump_exp
    function automatic int win_len(input int cfg, input int dur);
        return (dur + 1) * 2 * (cfg + 1);
    endfunction : win_len
    ////////////////////////
    initial begin
        cyc(20000);
        miscompares++;
        conclude();
    end
    initial begin
        void'($urandom(32'hd24a));
        cyc(2);
        #1;
        check(32'({hready, hresp, pump_up, pump_dn, pump_hiz, locked, pin}), 32'h4);
        cyc(2);
        reset_i <= 1'b0;
        cyc(1);
        for (int i = 1; i < 33; i++) rd_chk(8'(i), 32'h0);
        $display("reset test done");
        repeat (4) begin
            v = $urandom;
            wr(REG_PFD_CTRL_IDX, v);
            rd_chk(REG_PFD_CTRL_IDX, v & 32'h7);
            wr(REG_LOCK_CFG_IDX, v & 32'hff3ff);
            rd_chk(REG_LOCK_CFG_IDX, v & 32'hff3ff);
            wr(REG_GPO_CFG_IDX, v);
            rd_chk(REG_GPO_CFG_IDX, v & 32'hf);
            wr(REG_CORE_CTRL_IDX, v);
            rd_chk(REG_CORE_CTRL_IDX, v & 32'h800);
            wr(8'h20, v);
            rd_chk(8'h20, 32'h0);
        end
        wr(REG_LOCK_CFG_IDX, 32'h0);
        wr(REG_GPO_CFG_IDX, 32'h0);
        wr(REG_CORE_CTRL_IDX, 32'h0);
        $display("register test done");
        for (int c = 0; c < 8; c++) begin
            wr(REG_PFD_CTRL_IDX, 32'(c));
            for (int f = 0; f < 2; f++) begin
                one(f[0], ~f[0]);
                check(32'({pump_up, pump_dn, pump_hiz}), 32'(pump_exp(3'(c), f[0])));
                one(~f[0], f[0]);
                check(32'({pump_up, pump_dn, pump_hiz}), 32'(c[2:1] == 2'b00));
            end
        end
        $display("pump test done");
        wr(REG_PFD_CTRL_IDX, 32'h6);
        wr(REG_CORE_CTRL_IDX, 32'h800);
        mx = $urandom_range(6, 2);
        wr(REG_LOCK_CFG_IDX, 32'h2000 | 32'(mx));
        repeat (mx - 1) pulse(0);
        check(32'(locked), 32'h0);
        pulse($urandom_range(1, 0));
        check(32'(locked), 32'h1);
        check(32'(pin), 32'h1);
        rd_chk(REG_LOCK_STAT_IDX, 32'h1);
        wr(REG_LOCK_STAT_IDX, 32'h0);
        check(32'(hresp), 32'(HRESP_OKAY));
        rd_chk(REG_LOCK_STAT_IDX, 32'h1);
        pulse(2);
        check(32'(locked), 32'h0);
        check(32'(pin), 32'h0);
        repeat (mx - 1) pulse(0);
        check(32'(locked), 32'h0);
        pulse(0);
        check(32'(locked), 32'h1);
        $display("analog lock test done");
        for (int c = 0; c < 4; c++) begin
            d = $urandom_range(3, 0);
            wl = win_len(c, d);
            wr(REG_LOCK_CFG_IDX, 32'h4001 | (32'(c) << 15) | (32'(d) << 17));
            // miss first, so the hit below must set the flag itself
            pulse(wl);
            check(32'(locked), 32'h0);
            pulse(wl - 1);
            check(32'(locked), 32'h1);
        end
        $display("digital window test done");
        wr(REG_GPO_CFG_IDX, 32'(GPO_SEL_AUX_OSC));
        wr(REG_LOCK_CFG_IDX, 32'h80001);
        cyc(1);
        toggles(tg);
        check(tg, 32'd16);
        repeat (2) pulse(0);
        check(32'(locked), 32'h0);
        wr(REG_GPO_CFG_IDX, 32'h0);
        cyc(2);
        toggles(tg);
        check(32'(tg), 32'h0);
        $display("ring test done");
        wr(REG_LOCK_CFG_IDX, 32'h1001);
        pulse(0);
        check(32'(pin), 32'h1);
        repeat (4) begin
            v = $urandom;
            u_pfl_host.serial_bit(v[0]);
            #1;
            check(32'(pin), 32'(v[0]));
        end
        u_pfl_host.serial_end();
        #1;
        check(32'(pin), 32'h1);
        wr(REG_LOCK_CFG_IDX, 32'h1);
        // flag is set here, so a low data bit tells the two sources apart
        u_pfl_host.serial_bit(1'b0);
        #1;
        check(32'(pin), 32'h0);
        wr(REG_LOCK_CFG_IDX, 32'h3001);
        u_pfl_host.serial_bit(1'b0);
        #1;
        check(32'(pin), 32'h1);
        u_pfl_host.serial_end();
        $display("pin test done");
        wr(REG_CORE_CTRL_IDX, 32'h0);
        cyc(3);
        #1;
        check(32'(locked), 32'h0);
        repeat (2) pulse(0);
        check(32'(locked), 32'h0);
        $display("disable test done");
        conclude();
    end
endmodule : pfd_control_lock_detect_test
